// ==== gef_pkg.sv ====
// Constants, register map and field layout for the global event flags block
// Overview of operation
// - All flags reset to zero, stay set, and clear when their register is read.
// - Dropout detector rising sets bit 7 of the first flag register.
// - Temperature rising above the high alarm sets bit 5 of first register.
// - Temperature rising above the low alarm sets bit 4 of first register.
// - Rising edge of the active-low enable pin sets bit 3 of first register.
// - Falling edge of the active-low enable pin sets bit 2 of first register.
// - General input 0 rising sets bit 1, falling sets bit 0, first register.
// - General input edges count only while that pin is configured as input.
// - Linear regulator losing regulation sets bit 5 of the second register.
// - Switching regulator channel timeout sets bit 4 of the second register.
// - General input 1 rising sets bit 1, falling sets bit 0, second register.
// - Reserved bits are written as zero and read values are meaningless; host writes to the second flag register pass bits 7, 3 and 2.
// - Second mask register resets to ones, reserved positions to zero.
`default_nettype none
package gef_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_FLAGS_A = 8'h00;
  localparam logic [7:0] ADDR_FLAGS_B = 8'h04;
  localparam logic [7:0] ADDR_MASK_B = 8'h08;
  localparam logic [7:0] ADDR_MASK_A = 8'h09;
  // Implemented bit positions of each register
  localparam logic [7:0] FLAGS_A_USED = 8'hBF;
  localparam logic [7:0] FLAGS_B_USED = 8'h33;
  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] MASK_A_RST = 8'hBF;
  localparam logic [7:0] MASK_B_RST = 8'h33;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  // Field positions, first flag register
  localparam int BIT_DROPOUT_RISE = 7;
  localparam int BIT_THERM_HI_RISE = 5;
  localparam int BIT_THERM_LO_RISE = 4;
  localparam int BIT_EN_RISE = 3;
  localparam int BIT_EN_FALL = 2;
  localparam int BIT_GPI0_RISE = 1;
  localparam int BIT_GPI0_FALL = 0;
  // Field positions, second flag register
  localparam int BIT_LDO_FAULT = 5;
  localparam int BIT_SWITCHER_TIMEOUT = 4;
  localparam int BIT_GPI1_RISE = 1;
  localparam int BIT_GPI1_FALL = 0;
  // Lanes of the shared edge detector
  localparam int EV_DROPOUT = 0;
  localparam int EV_THERM_HI = 1;
  localparam int EV_THERM_LO = 2;
  localparam int EV_ENABLE = 3;
  localparam int EV_GPI0 = 4;
  localparam int EV_GPI1 = 5;
  localparam int EV_LDO_FAULT = 6;
  localparam int EV_SWITCHER_TIMEOUT = 7;
  localparam int EV_COUNT = 8;
endpackage
`default_nettype wire

// ==== gef_edge_detect.sv ====
// Per-lane rising and falling edge detector for event sources
`timescale 1ns/10ps
`default_nettype none
module gef_edge_detect #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Sampled levels and detected edges
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] prev_q, prev_d;
  logic primed_q, primed_d;

  // Next history; primed blocks a false edge on the first sample
  always_comb begin
    prev_d = level;
    primed_d = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= '0;
      primed_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      primed_q <= primed_d;
    end
  end

  // Edge lanes
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_lane
      assign rise[g] = primed_q & level[g] & ~prev_q[g];
      assign fall[g] = primed_q & ~level[g] & prev_q[g];
    end
  endgenerate
endmodule
`default_nettype wire

// ==== gef_event_flags.sv ====
// Global event flag registers with read-to-clear and masked interrupt
`timescale 1ns/10ps
`default_nettype none
module gef_event_flags
  import gef_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register access from the serial interface engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd_en,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Event sources, synchronous levels
  input wire logic dropout_det,
  input wire logic temp_above_hi,
  input wire logic temp_above_lo,
  input wire logic enable_pin_active_low,
  input wire logic gen_input0,
  input wire logic gen_input1,
  input wire logic gen_input0_is_input,
  input wire logic gen_input1_is_input,
  input wire logic linear_reg_out_of_reg,
  input wire logic switcher_timeout,
  // Interrupt request
  output logic irq_n
);
  logic [EV_COUNT-1:0] ev_level, ev_rise, ev_fall;
  logic [7:0] set_a, set_b;
  logic rd_a, rd_b;
  logic [7:0] flags_a_q, flags_a_d, flags_b_q, flags_b_d;
  logic [7:0] mask_a_q, mask_a_d, mask_b_q, mask_b_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d, irq_n_q, irq_n_d;

  // Address match, used for reads and writes alike
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction

  // Gather event levels into detector lanes
  always_comb begin
    ev_level = '0;
    ev_level[EV_DROPOUT] = dropout_det;
    ev_level[EV_THERM_HI] = temp_above_hi;
    ev_level[EV_THERM_LO] = temp_above_lo;
    ev_level[EV_ENABLE] = enable_pin_active_low;
    ev_level[EV_GPI0] = gen_input0;
    ev_level[EV_GPI1] = gen_input1;
    ev_level[EV_LDO_FAULT] = linear_reg_out_of_reg;
    ev_level[EV_SWITCHER_TIMEOUT] = switcher_timeout;
  end

  gef_edge_detect #(
    .WIDTH(EV_COUNT)
  ) u_edges (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .level(ev_level),
    .rise(ev_rise),
    .fall(ev_fall)
  );

  // Map edges onto flag positions; reserved bits never set
  always_comb begin
    set_a = '0;
    set_b = '0;
    set_a[BIT_DROPOUT_RISE] = ev_rise[EV_DROPOUT];
    set_a[BIT_THERM_HI_RISE] = ev_rise[EV_THERM_HI];
    set_a[BIT_THERM_LO_RISE] = ev_rise[EV_THERM_LO];
    set_a[BIT_EN_RISE] = ev_rise[EV_ENABLE];
    set_a[BIT_EN_FALL] = ev_fall[EV_ENABLE];
    // Pins driven as outputs produce no events
    set_a[BIT_GPI0_RISE] = ev_rise[EV_GPI0] & gen_input0_is_input;
    set_a[BIT_GPI0_FALL] = ev_fall[EV_GPI0] & gen_input0_is_input;
    set_b[BIT_LDO_FAULT] = ev_rise[EV_LDO_FAULT];
    set_b[BIT_SWITCHER_TIMEOUT] = ev_rise[EV_SWITCHER_TIMEOUT];
    set_b[BIT_GPI1_RISE] = ev_rise[EV_GPI1] & gen_input1_is_input;
    set_b[BIT_GPI1_FALL] = ev_fall[EV_GPI1] & gen_input1_is_input;
  end

  // Flag, mask and read path next values
  always_comb begin
    rd_a = reg_rd_en & hit(reg_addr, ADDR_FLAGS_A);
    rd_b = reg_rd_en & hit(reg_addr, ADDR_FLAGS_B);
    // Set beats the read clear so a same-cycle event is kept
    flags_a_d = ((rd_a ? FLAGS_RST : flags_a_q) | set_a) & FLAGS_A_USED;
    flags_b_d = ((rd_b ? FLAGS_RST : flags_b_q) | set_b) & FLAGS_B_USED;
    mask_a_d = mask_a_q;
    mask_b_d = mask_b_q;
    // Reserved write bits are dropped, so they always read zero
    if (reg_wr_en && hit(reg_addr, ADDR_MASK_A)) begin
      mask_a_d = reg_wdata & FLAGS_A_USED;
    end else if (reg_wr_en && hit(reg_addr, ADDR_MASK_B)) begin
      mask_b_d = reg_wdata & FLAGS_B_USED;
    end
    rvalid_d = reg_rd_en;
    rdata_d = rdata_q;
    if (reg_rd_en) begin
      if (rd_a) begin
        rdata_d = flags_a_q;
      end else if (rd_b) begin
        rdata_d = flags_b_q;
      end else if (hit(reg_addr, ADDR_MASK_A)) begin
        rdata_d = mask_a_q;
      end else if (hit(reg_addr, ADDR_MASK_B)) begin
        rdata_d = mask_b_q;
      end else begin
        rdata_d = RDATA_UNMAPPED;
      end
    end
    // Interrupt from next state so it drops with the clearing read
    irq_n_d = ~(|(flags_a_d & ~mask_a_d) | |(flags_b_d & ~mask_b_d));
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_a_q <= FLAGS_RST;
      flags_b_q <= FLAGS_RST;
      mask_a_q <= MASK_A_RST;
      mask_b_q <= MASK_B_RST;
      rdata_q <= RDATA_UNMAPPED;
      rvalid_q <= 1'b0;
      irq_n_q <= 1'b1;
    end else begin
      flags_a_q <= flags_a_d;
      flags_b_q <= flags_b_d;
      mask_a_q <= mask_a_d;
      mask_b_q <= mask_b_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      irq_n_q <= irq_n_d;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign irq_n = irq_n_q;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_read_a;
    reg_rd_en && reg_addr == ADDR_FLAGS_A;
  endsequence
  sequence s_read_b;
    reg_rd_en && reg_addr == ADDR_FLAGS_B;
  endsequence

  a_read_clears_a: assert property (
    reg_rd_en && reg_addr == ADDR_FLAGS_A && set_a == 8'h00
      |=> flags_a_q == 8'h00)
    else $error("first flag register not cleared by read");
  a_read_returns_a: assert property (
    s_read_a |=> reg_rvalid && reg_rdata == $past(flags_a_q))
    else $error("read of first flag register returned wrong data");
  a_flag_sticky: assert property (
    !(reg_rd_en && reg_addr == ADDR_FLAGS_B) |=>
      (flags_b_q & $past(flags_b_q)) == $past(flags_b_q))
    else $error("second register flag dropped without a read");
  a_dropout_rise: assert property (
    ev_rise[EV_DROPOUT] && !mask_a_q[BIT_DROPOUT_RISE] &&
      !(reg_wr_en && reg_addr == ADDR_MASK_A)
      |=> flags_a_q[BIT_DROPOUT_RISE] && !irq_n)
    else $error("unmasked dropout rise did not raise the interrupt");
  a_dropout_set: assert property (
    dropout_det && !$past(dropout_det) && u_edges.primed_q
      |=> flags_a_q[7])
    else $error("dropout rise did not set bit 7");
  a_thermal_set: assert property (
    set_a[BIT_THERM_HI_RISE] |=> flags_a_q[5] ##0 !irq_n || mask_a_q[5])
    else $error("high thermal alarm did not set bit 5");
  a_thermal_lo_set: assert property (
    temp_above_lo && !$past(temp_above_lo) && u_edges.primed_q
      |=> flags_a_q[4])
    else $error("low thermal alarm did not set bit 4");
  a_enable_edges: assert property (
    (ev_rise[EV_ENABLE] |=> flags_a_q[3]) and
    (ev_fall[EV_ENABLE] |=> flags_a_q[2]))
    else $error("enable pin edge not flagged");
  a_gpi0_gate: assert property (
    !gen_input0_is_input && !flags_a_q[1] |=> !flags_a_q[1])
    else $error("output-mode pin raised an edge flag");
  a_gpi1_edges: assert property (
    gen_input1_is_input && ev_fall[EV_GPI1] |=> flags_b_q[0])
    else $error("input 1 falling edge not flagged");
  a_fault_timeout: assert property (
    (ev_rise[EV_LDO_FAULT] |=> flags_b_q[5]) and
    (ev_rise[EV_SWITCHER_TIMEOUT] |=> flags_b_q[4]))
    else $error("regulator fault or timeout not flagged");
  a_reserved_zero: assert property (
    (flags_a_q & ~FLAGS_A_USED) == 8'h00 &&
    (flags_b_q & ~FLAGS_B_USED) == 8'h00 &&
    (mask_b_q & ~FLAGS_B_USED) == 8'h00)
    else $error("reserved bit set");
  a_irq_follows: assert property (
    !irq_n == (|(flags_a_q & ~mask_a_q) || |(flags_b_q & ~mask_b_q)))
    else $error("interrupt output disagrees with unmasked flags");

  // Second register read path, first register stickiness, input gating and the read answer
  a_read_returns_b: assert property (
    s_read_b |=> reg_rvalid && reg_rdata == $past(flags_b_q))
    else $error("read of second flag register returned wrong data");
  a_read_clears_b: assert property (
    reg_rd_en && reg_addr == ADDR_FLAGS_B && set_b == 8'h00
      |=> flags_b_q == 8'h00)
    else $error("second flag register not cleared by read");
  a_flag_a_sticky: assert property (
    !(reg_rd_en && reg_addr == ADDR_FLAGS_A) |=>
      (flags_a_q & $past(flags_a_q)) == $past(flags_a_q))
    else $error("first register flag dropped without a read");
  a_gpi0_edges: assert property (
    (gen_input0_is_input && ev_rise[EV_GPI0] |=> flags_a_q[1]) and
    (gen_input0_is_input && ev_fall[EV_GPI0] |=> flags_a_q[0]))
    else $error("input 0 edge not flagged");
  a_gpi1_gate: assert property (
    !gen_input1_is_input && !flags_b_q[0] |=> !flags_b_q[0])
    else $error("output-mode pin raised a falling edge flag");
  a_rvalid_pulse: assert property (
    !reg_rd_en |=> !reg_rvalid)
    else $error("read valid without a read strobe");
endmodule
`default_nettype wire

// ==== gef_host_model.sv ====
// Host processor model driving the register port of the event flags block
`timescale 1ns/10ps
`default_nettype none
module gef_host_model
  import gef_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Register port, host side
  output logic [7:0] reg_addr,
  output logic reg_rd_en,
  output logic reg_wr_en,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // Idle values; released lines show inverted leftovers, never stale data
  initial begin
    reg_addr = 8'hFF;
    reg_rd_en = 1'b0;
    reg_wr_en = 1'b0;
    reg_wdata = 8'hFF;
  end

  // One-cycle write strobe, reserved bits sent as zero except bits 7, 3 and 2 of the second flag register
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d & (a == ADDR_MASK_B ? FLAGS_B_USED : FLAGS_A_USED);
    reg_wr_en = 1'b1;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~reg_wdata;
  endtask

  // One-cycle read strobe, then a bounded wait for the valid pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    ok = 1'b0;
    d = 8'h00;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d = reg_rdata;
      end else begin
        @(negedge sys_clk);
      end
    end
  endtask
endmodule
`default_nettype wire

// ==== global_event_flag_registers_tb.sv ====
// Self-checking bench for the global event flags block
`timescale 1ns/10ps
`default_nettype none
module global_event_flag_registers_tb
  import gef_pkg::*;
;
  `define CHK(g, e) begin \
    compares++; \
    if ((g) !== (e)) begin \
      num_errors++; \
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e); \
    end \
  end
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] ev = 8'h08; // Lanes as EV_*; enable pin idles high
  logic [1:0] gp_in = 2'b11;
  logic [7:0] addr, wdata, rdata, d;
  logic rd_en, wr_en, rvalid, irq_n, ok;
  int num_errors = 0;
  int compares = 0;
  // Rows: lane to toggle, register, expected flags after the toggle
  logic [19:0] rows [16] = '{
    20'h00080, 20'h00000, 20'h10020, 20'h10000,
    20'h20010, 20'h20000, 20'h30004, 20'h30008,
    20'h40002, 20'h40001, 20'h50402, 20'h50401,
    20'h60420, 20'h60400, 20'h70410, 20'h70400
  };

  always #5 sys_clk = ~sys_clk;

  gef_event_flags dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(addr),
    .reg_rd_en(rd_en), .reg_wr_en(wr_en), .reg_wdata(wdata),
    .reg_rdata(rdata), .reg_rvalid(rvalid), .dropout_det(ev[EV_DROPOUT]),
    .temp_above_hi(ev[EV_THERM_HI]), .temp_above_lo(ev[EV_THERM_LO]),
    .enable_pin_active_low(ev[EV_ENABLE]), .gen_input0(ev[EV_GPI0]),
    .gen_input1(ev[EV_GPI1]), .gen_input0_is_input(gp_in[0]),
    .gen_input1_is_input(gp_in[1]),
    .linear_reg_out_of_reg(ev[EV_LDO_FAULT]),
    .switcher_timeout(ev[EV_SWITCHER_TIMEOUT]), .irq_n(irq_n));

  gef_host_model host (.sys_clk(sys_clk), .reg_addr(addr),
    .reg_rd_en(rd_en), .reg_wr_en(wr_en), .reg_wdata(wdata),
    .reg_rdata(rdata), .reg_rvalid(rvalid));

  // Closing report, reached from the main sequence or the watchdog
  task automatic give_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Read and compare; reserved positions carry no meaning, so masked off
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] m;
    m = (a == ADDR_FLAGS_A || a == ADDR_MASK_A) ?
        FLAGS_A_USED : FLAGS_B_USED;
    host.rd(a, d, ok);
    `CHK(ok, 1'b1)
    // No answer: stop here rather than compare stale data
    if (ok !== 1'b1) begin
      give_verdict();
    end
    `CHK(d & m, e & m)
  endtask

  // Hang guard
  initial begin
    #500000;
    num_errors++;
    give_verdict();
  end

  initial begin
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    `CHK(irq_n, 1'b1)
    rd_chk(ADDR_FLAGS_A, FLAGS_RST);
    rd_chk(ADDR_FLAGS_B, FLAGS_RST);
    rd_chk(ADDR_MASK_B, MASK_B_RST);
    rd_chk(8'h3F, RDATA_UNMAPPED);
    // Masks block everything here, so the interrupt must stay high
    for (int i = 0; i < 16; i++) begin
      ev[rows[i][19:16]] = ~ev[rows[i][19:16]];
      repeat (3) @(negedge sys_clk);
      `CHK(irq_n, 1'b1)
      rd_chk(rows[i][15:8], rows[i][7:0]);
      rd_chk(rows[i][15:8], 8'h00);
    end
    // Flag registers ignore writes
    host.wr(ADDR_FLAGS_A, 8'hBF);
    rd_chk(ADDR_FLAGS_A, 8'h00);
    // Unmasked dropout pulls the interrupt low until the read
    host.wr(ADDR_MASK_A, 8'h00);
    ev[EV_DROPOUT] = 1'b1;
    repeat (3) @(negedge sys_clk);
    `CHK(irq_n, 1'b0)
    rd_chk(ADDR_FLAGS_A, 8'h80);
    @(negedge sys_clk);
    `CHK(irq_n, 1'b1)
    // Pins set as outputs: edges must not flag, interrupt is unmasked
    host.wr(ADDR_MASK_B, 8'h00);
    gp_in = 2'b00;
    ev[EV_GPI0] = 1'b1;
    ev[EV_GPI1] = 1'b1;
    repeat (3) @(negedge sys_clk);
    `CHK(irq_n, 1'b1)
    rd_chk(ADDR_FLAGS_A, 8'h00);
    rd_chk(ADDR_FLAGS_B, 8'h00);
    // Event in the same cycle as the clearing read outlives the read
    gp_in = 2'b11;
    fork
      host.rd(ADDR_FLAGS_B, d, ok);
      begin
        @(negedge sys_clk);
        ev[EV_LDO_FAULT] = 1'b1;
      end
    join
    `CHK(ok, 1'b1)
    `CHK(d & FLAGS_B_USED, 8'h00)
    `CHK(irq_n, 1'b0)
    rd_chk(ADDR_FLAGS_B, 8'h20);
    // Pending unmasked flag, then a mid-run reset clears it all
    ev[EV_THERM_LO] = 1'b1;
    repeat (2) @(negedge sys_clk);
    `CHK(irq_n, 1'b0)
    rst_n = 1'b0;
    @(negedge sys_clk);
    `CHK(irq_n, 1'b1)
    `CHK(rvalid, 1'b0)
    `CHK(rdata, RDATA_UNMAPPED)
    // A level raised under reset must not flag at release
    ev[EV_THERM_HI] = 1'b1;
    @(negedge sys_clk);
    rst_n = 1'b1;
    rd_chk(ADDR_FLAGS_A, FLAGS_RST);
    rd_chk(ADDR_FLAGS_B, FLAGS_RST);
    rd_chk(ADDR_MASK_A, MASK_A_RST);
    rd_chk(ADDR_MASK_B, MASK_B_RST);
    give_verdict();
  end
endmodule
`default_nettype wire
